// ---- rtl/psr_pkg.sv ----
package psr_pkg;

  // Management register addresses
  localparam logic [4:0] ADDR_STATUS   = 5'h01;
  localparam logic [4:0] ADDR_ID_UPPER = 5'h02;
  localparam logic [4:0] ADDR_ID_LOWER = 5'h03;

  // Status register bit positions
  localparam int BIT_T4       = 15;
  localparam int BIT_TX_FDX   = 14;
  localparam int BIT_TX_HDX   = 13;
  localparam int BIT_10_FDX   = 12;
  localparam int BIT_10_HDX   = 11;
  localparam int BIT_RSV_HI   = 10;
  localparam int BIT_RSV_LO   = 7;
  localparam int BIT_PRE_SKIP = 6;
  localparam int BIT_AN_DONE  = 5;
  localparam int BIT_RFAULT   = 4;
  localparam int BIT_AN_ABLE  = 3;
  localparam int BIT_LINK     = 2;
  localparam int BIT_JABBER   = 1;
  localparam int BIT_EXT      = 0;

  // Identifier field slices
  localparam int OUI_UP_HI  = 21;
  localparam int OUI_UP_LO  = 6;
  localparam int OUI_LOW_HI = 5;

  // Frame layout, in management clock periods
  localparam logic [5:0] PRE_FULL   = 6'h20;
  localparam logic [5:0] PRE_SHORT  = 6'h02;
  localparam logic [5:0] HDR_BITS   = 6'h0D;
  localparam logic [5:0] DATA_BITS  = 6'h10;
  localparam logic [5:0] BODY_BITS  = 6'h12;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic       START_LAST = 1'h1;

  typedef enum logic [2:0] {
    PSR_PRE,
    PSR_HDR,
    PSR_TURN,
    PSR_RDAT,
    PSR_BODY
  } psr_state_t;

endpackage

// ---- rtl/psr_status_id.sv ----
// Operation
// - Status bit 15 always reads 0
// - Status bits 14 to 11 always read 1
// - Reserved status bits 10 to 7 read 0
// - Only status bit 6 writable, reset 0
// - Skip bit allows two-bit preamble frames
// - Bit 5 shows auto-negotiation complete
// - Remote fault latched until read and gone
// - Bit 3 always reads 1
// - Bit 2 shows link pass state
// - Link failure held low until read
// - Jabber in 10 Mb/s latched until read
// - Bit 0 always reads 1
// - Status decoded at address 1
// - Address 2 holds identifier bits 21:6
// - Address 3 packs identifier, model, revision
// - Identifier bits 23:22 are dropped
// - Read data sent MSB first after turnaround
`timescale 1ns/1ps
module psr_status_id #(
  parameter logic [23:0] OUI_VALUE   = 24'h0A5A5A, // Arbitrary value
  parameter logic [5:0]  MODEL_VALUE = 6'h15,      // Arbitrary value
  parameter logic [3:0]  REV_VALUE   = 4'h1        // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe_n,
  input  wire logic [4:0] phy_addr,
  input  wire logic       an_complete,
  input  wire logic       far_end_fault,
  input  wire logic       link_pass,
  input  wire logic       jabber_seen,
  input  wire logic       ten_mb_mode,
  output logic            preamble_skip_enable
);

  typedef struct packed {
    logic                mdc_s1;
    logic                mdc_s2;
    logic                mdc_s3;
    logic                mdio_s1;
    logic                mdio_s2;
    logic [4:0]          adr_s1;
    logic [4:0]          adr_s2;
    psr_pkg::psr_state_t state;
    logic [5:0]          cnt;
    logic [12:0]         hdr;
    logic [15:0]         wdat;
    logic [15:0]         shadow;
    logic                mine_wr;
    logic                link_q;
    logic                fail_held;
    logic                rf_held;
    logic                jab_held;
    logic                ev_fail;
    logic                ev_rf;
    logic                ev_jab;
    logic                skip;
    logic                mdio_out;
    logic                mdio_oe_n;
  } psr_regs_t;

  psr_regs_t s;
  psr_regs_t next_s;

  function automatic logic [15:0] status_word(
    input logic skip,
    input logic an_done,
    input logic rf,
    input logic link,
    input logic jab
  );
    logic [15:0] w;
    w = '0;
    w[psr_pkg::BIT_T4] = 1'b0;
    w[psr_pkg::BIT_TX_FDX] = 1'b1;
    w[psr_pkg::BIT_TX_HDX] = 1'b1;
    w[psr_pkg::BIT_10_FDX] = 1'b1;
    w[psr_pkg::BIT_10_HDX] = 1'b1;
    w[psr_pkg::BIT_RSV_HI:psr_pkg::BIT_RSV_LO] = '0;
    w[psr_pkg::BIT_PRE_SKIP] = skip;
    w[psr_pkg::BIT_AN_DONE] = an_done;
    w[psr_pkg::BIT_RFAULT] = rf;
    w[psr_pkg::BIT_AN_ABLE] = 1'b1;
    w[psr_pkg::BIT_LINK] = link;
    w[psr_pkg::BIT_JABBER] = jab;
    w[psr_pkg::BIT_EXT] = 1'b1;
    return w;
  endfunction

  logic        rise;
  logic        bit_in;
  logic        ev_fail_now;
  logic        ev_rf_now;
  logic        ev_jab_now;
  logic        capture;
  logic        rd_done;
  logic [4:0]  hdr_phy;
  logic [4:0]  hdr_reg;
  logic [1:0]  hdr_op;
  logic [15:0] wword;
  logic [15:0] id_upper;
  logic [15:0] id_lower;
  logic [15:0] rd_word;
  logic        reg_hit;
  logic [5:0]  pre_need;

  always_comb
  begin
    next_s = s;
    next_s.mdc_s1 = mdc;
    next_s.mdc_s2 = s.mdc_s1;
    next_s.mdc_s3 = s.mdc_s2;
    next_s.mdio_s1 = mdio_in;
    next_s.mdio_s2 = s.mdio_s1;
    next_s.adr_s1 = phy_addr;
    next_s.adr_s2 = s.adr_s1;
    next_s.link_q = link_pass;

    // Only the second and third synchroniser stages feed the edge detector
    rise = s.mdc_s2 & ~s.mdc_s3;
    bit_in = s.mdio_s2;

    ev_fail_now = s.link_q & ~link_pass;
    ev_rf_now = far_end_fault;
    ev_jab_now = jabber_seen & ten_mb_mode;

    capture = 1'b0;
    rd_done = 1'b0;
    // Twelve header bits are in, the last register bit is still on the line,
    // so start, op and PHY address sit one place lower than after the final shift
    hdr_op = s.hdr[10:9];
    hdr_phy = s.hdr[8:4];
    hdr_reg = {s.hdr[3:0], bit_in};
    wword = {s.wdat[14:0], bit_in};

    // The two top identifier bits have no place in either register
    id_upper = OUI_VALUE[psr_pkg::OUI_UP_HI:psr_pkg::OUI_UP_LO];
    id_lower = {OUI_VALUE[psr_pkg::OUI_LOW_HI:0], MODEL_VALUE, REV_VALUE};

    reg_hit = 1'b1;
    case (hdr_reg)
      psr_pkg::ADDR_STATUS:
        rd_word = status_word(s.skip, an_complete, s.rf_held,
                              link_pass & ~s.fail_held, s.jab_held);
      psr_pkg::ADDR_ID_UPPER:
        rd_word = id_upper;
      psr_pkg::ADDR_ID_LOWER:
        rd_word = id_lower;
      default:
      begin
        rd_word = '0;
        reg_hit = 1'b0;
      end
    endcase

    // A shortened preamble is only honoured once software set the skip bit
    pre_need = s.skip ? psr_pkg::PRE_SHORT : psr_pkg::PRE_FULL;

    if (rise)
    begin
      case (s.state)
        psr_pkg::PSR_PRE:
        begin
          if (bit_in)
          begin
            if (s.cnt < psr_pkg::PRE_FULL)
              next_s.cnt = s.cnt + 6'h01;
          end
          else if (s.cnt >= pre_need)
          begin
            next_s.state = psr_pkg::PSR_HDR;
            next_s.cnt = '0;
          end
          else
            next_s.cnt = '0;
        end
        psr_pkg::PSR_HDR:
        begin
          next_s.hdr = {s.hdr[11:0], bit_in};
          next_s.cnt = s.cnt + 6'h01;
          if (s.cnt == psr_pkg::HDR_BITS - 6'h01)
          begin
            next_s.cnt = '0;
            next_s.mine_wr = 1'b0;
            if (s.hdr[11] == psr_pkg::START_LAST && hdr_phy == s.adr_s2 &&
                hdr_op == psr_pkg::OP_READ && reg_hit)
            begin
              next_s.state = psr_pkg::PSR_TURN;
              next_s.shadow = rd_word;
              capture = 1'b1;
            end
            else
            begin
              next_s.state = psr_pkg::PSR_BODY;
              // Only bit 6 of a status write is kept; other registers ignore writes
              next_s.mine_wr = s.hdr[11] == psr_pkg::START_LAST &&
                               hdr_phy == s.adr_s2 &&
                               hdr_op == psr_pkg::OP_WRITE &&
                               hdr_reg == psr_pkg::ADDR_STATUS;
            end
          end
        end
        psr_pkg::PSR_TURN:
        begin
          // First turnaround bit stays released, the second is driven low
          next_s.mdio_oe_n = 1'b0;
          next_s.mdio_out = 1'b0;
          next_s.state = psr_pkg::PSR_RDAT;
          next_s.cnt = '0;
        end
        psr_pkg::PSR_RDAT:
        begin
          next_s.cnt = s.cnt + 6'h01;
          if (s.cnt == psr_pkg::DATA_BITS)
          begin
            next_s.mdio_oe_n = 1'b1;
            next_s.mdio_out = 1'b1;
            next_s.state = psr_pkg::PSR_PRE;
            next_s.cnt = '0;
            // The header is complete here, so the register field is its low five bits
            rd_done = s.hdr[4:0] == psr_pkg::ADDR_STATUS;
          end
          else
          begin
            next_s.mdio_out = s.shadow[15];
            next_s.shadow = {s.shadow[14:0], 1'b0};
          end
        end
        psr_pkg::PSR_BODY:
        begin
          next_s.wdat = wword;
          next_s.cnt = s.cnt + 6'h01;
          if (s.cnt == psr_pkg::BODY_BITS - 6'h01)
          begin
            next_s.state = psr_pkg::PSR_PRE;
            next_s.cnt = '0;
            if (s.mine_wr)
              next_s.skip = wword[psr_pkg::BIT_PRE_SKIP];
          end
        end
        default:
        begin
          next_s.state = psr_pkg::PSR_PRE;
          next_s.cnt = '0;
          next_s.mdio_oe_n = 1'b1;
          next_s.mdio_out = 1'b1;
        end
      endcase
    end

    // Events seen after the snapshot survive the clear at frame end
    if (capture)
    begin
      next_s.ev_fail = ev_fail_now;
      next_s.ev_rf = ev_rf_now;
      next_s.ev_jab = ev_jab_now;
    end
    else
    begin
      next_s.ev_fail = s.ev_fail | ev_fail_now;
      next_s.ev_rf = s.ev_rf | ev_rf_now;
      next_s.ev_jab = s.ev_jab | ev_jab_now;
    end

    // A status read clears only what it reported; a new event wins over the clear
    if (rd_done)
    begin
      next_s.fail_held = s.ev_fail | ev_fail_now;
      next_s.rf_held = s.ev_rf | ev_rf_now;
      next_s.jab_held = s.ev_jab | ev_jab_now;
    end
    else
    begin
      next_s.fail_held = s.fail_held | ev_fail_now;
      next_s.rf_held = s.rf_held | ev_rf_now;
      next_s.jab_held = s.jab_held | ev_jab_now;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Line released and pulled high while in reset
      s <= '0;
      s.state <= psr_pkg::PSR_PRE;
      s.mdio_out <= 1'b1;
      s.mdio_oe_n <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign mdio_out = s.mdio_out;
  assign mdio_oe_n = s.mdio_oe_n;
  assign preamble_skip_enable = s.skip;

endmodule

// ---- tb/psr_status_id_properties.sv ----
`timescale 1ns/1ps
module psr_status_id_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  input wire logic preamble_skip_enable
);
  logic [8:0] drv_cnt;
  logic [4:0] low_cnt;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      drv_cnt <= 9'h000;
      low_cnt <= 5'h00;
    end
    else
    begin
      drv_cnt <= mdio_oe_n ? 9'h000 : drv_cnt + 9'h001;
      low_cnt <= mdc ? 5'h00 : low_cnt + {4'h0, low_cnt != 5'h1F};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST_IDLE: assert property ($fell(rst) |-> mdio_oe_n && mdio_out && !preamble_skip_enable)
    else $error("outputs not idle after reset");
  AST_IDLE_HIGH: assert property (mdio_oe_n |-> mdio_out)
    else $error("released line not high");
  AST_TA_ZERO: assert property ($fell(mdio_oe_n) |-> !mdio_out && mdc)
    else $error("turnaround bit not zero");
  AST_OUT_ON_MDC: assert property ($changed(mdio_out) |-> mdc)
    else $error("data changed away from mdc rise");
  // 17 bit times at 125 ns is about 266 cycles, 260 to 270 accepted
  AST_DRIVE_LEN: assert property ($rose(mdio_oe_n) |-> drv_cnt >= 9'h104 && drv_cnt <= 9'h10E)
    else $error("drive length wrong");
  AST_DRIVE_NEEDS_MDC: assert property (!mdio_oe_n |-> low_cnt < 5'h0F)
    else $error("driving with mdc stopped");
  AST_SKIP_AT_END: assert property ($changed(preamble_skip_enable) |-> mdc && mdio_oe_n)
    else $error("skip bit changed outside frame end");
  AST_OE_STANDS: assert property ($changed(mdio_oe_n) |=> $stable(mdio_oe_n) [*8])
    else $error("enable glitch");
  COV_READ: cover property ($fell(mdio_oe_n));
  COV_SKIP_ON: cover property ($rose(preamble_skip_enable));
  COV_SKIP_OFF: cover property ($fell(preamble_skip_enable));
endmodule
bind psr_status_id psr_status_id_properties psr_status_id_properties_inst (
  .clk(clk), .rst(rst), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe_n(mdio_oe_n), .preamble_skip_enable(preamble_skip_enable)
);

// ---- tb/psr_smc.sv ----
`timescale 1ns/1ps
module psr_smc (
  output logic      mdc,
  output logic      drv,
  input  wire logic mdio_w
);
  initial
  begin
    mdc = 1'b0;
    drv = 1'b1;
  end
  // Clock stands low between frames, as a real controller may stop it
  task automatic bit_io(input logic b, output logic s);
    drv = b;
    #62.5 mdc = 1'b1;
    s = mdio_w;
    #62.5 mdc = 1'b0;
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, input int np, output logic [15:0] rd);
    logic [13:0] hdr;
    logic [17:0] body;
    logic        s;
    hdr = {2'h1, op, pa, ra};
    body = (op == 2'h2) ? 18'h3FFFF : {2'h2, wd};
    rd = 16'h0000;
    repeat (np) bit_io(1'b1, s);
    for (int i = 13; i >= 0; i--) bit_io(hdr[i], s);
    for (int i = 17; i >= 0; i--)
    begin
      bit_io(body[i], s);
      if (i < 16) rd[i] = s;
    end
    bit_io(1'b1, s);
  endtask
endmodule

// ---- tb/test_psr_status_id.sv ----
`timescale 1ns/1ps
module test_psr_status_id;
  localparam logic [23:0] OUI = 24'h3C96E1; // Arbitrary value
  localparam logic [5:0]  MDL = 6'h2B;      // Arbitrary value
  localparam logic [3:0]  RV  = 4'h7;       // Arbitrary value
  localparam logic [4:0]  PA  = 5'h05;
  // Register, inputs before, inputs at read {link, an, fault, jabber, ten}, expected
  logic [30:0] rows [15] = '{
    {5'h01, 5'h00, 5'h00, 16'h7809}, {5'h02, 5'h00, 5'h00, OUI[21:6]},
    {5'h03, 5'h00, 5'h00, OUI[5:0], MDL, RV}, {5'h01, 5'h10, 5'h10, 16'h780D},
    {5'h01, 5'h08, 5'h18, 16'h7829}, {5'h01, 5'h18, 5'h18, 16'h782D},
    {5'h01, 5'h14, 5'h10, 16'h781D}, {5'h01, 5'h10, 5'h10, 16'h780D},
    {5'h01, 5'h13, 5'h11, 16'h780F}, {5'h01, 5'h11, 5'h11, 16'h780D},
    {5'h01, 5'h12, 5'h10, 16'h780D}, {5'h01, 5'h14, 5'h14, 16'h781D},
    {5'h01, 5'h14, 5'h14, 16'h781D}, {5'h01, 5'h10, 5'h10, 16'h781D},
    {5'h01, 5'h10, 5'h10, 16'h780D}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  vin = 5'h00;
  logic [4:0]  ra, v0, v1;
  logic [15:0] rd, ex;
  int          num_errors = 0;
  int          cmp_count = 0;
  wire         mdc, drv, out, oe_n, skip;
  wire         mdio_w = drv & (oe_n | out);
  always #4 clk = ~clk;
  psr_status_id #(.OUI_VALUE(OUI), .MODEL_VALUE(MDL), .REV_VALUE(RV)) psr_status_id_inst (
    .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(out), .mdio_oe_n(oe_n),
    .phy_addr(PA), .an_complete(vin[3]), .far_end_fault(vin[2]), .link_pass(vin[4]),
    .jabber_seen(vin[1]), .ten_mb_mode(vin[0]), .preamble_skip_enable(skip));
  psr_smc psr_smc_inst (.mdc(mdc), .drv(drv), .mdio_w(mdio_w));
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] r,
                      input logic [15:0] wd, input int np);
    psr_smc_inst.frame(op, pa, r, wd, np, rd);
  endtask
  task automatic test_done;
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    // Pulses land before the read so latches must hold them
    foreach (rows[i])
    begin
      {ra, v0, v1, ex} = rows[i];
      vin = v0;
      repeat (4) @(negedge clk);
      vin = v1;
      repeat (4) @(negedge clk);
      xfer(2'h2, PA, ra, 16'h0000, 32);
      check("row", rd, ex);
    end
    xfer(2'h1, PA, 5'h01, 16'hFFFF, 32);
    check("skip_on", {15'h0000, skip}, 16'h0001);
    xfer(2'h1, PA, 5'h02, 16'h0000, 2);
    xfer(2'h2, PA, 5'h02, 16'h0000, 2);
    check("id_upper", rd, OUI[21:6]);
    xfer(2'h2, PA, 5'h01, 16'h0000, 2);
    check("status_written", rd, 16'h784D);
    xfer(2'h2, PA ^ 5'h01, 5'h01, 16'h0000, 32);
    check("other_phy", rd, 16'hFFFF);
    xfer(2'h2, PA, 5'h00, 16'h0000, 32);
    check("reg0", rd, 16'hFFFF);
    xfer(2'h1, PA, 5'h01, 16'h0000, 2);
    check("skip_off", {15'h0000, skip}, 16'h0000);
    xfer(2'h2, PA, 5'h01, 16'h0000, 2);
    check("short_preamble", rd, 16'hFFFF);
    xfer(2'h1, PA, 5'h01, 16'h0040, 32);
    check("skip_set", {15'h0000, skip}, 16'h0001);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check("reset_skip", {15'h0000, skip}, 16'h0000);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    xfer(2'h2, PA, 5'h01, 16'h0000, 32);
    check("reset_status", rd, 16'h780D);
    test_done;
  end
  initial
  begin
    #600000;
    num_errors++;
    test_done;
  end
endmodule
